// ==== hw/wcsl_loader.sv ====
// Wiper code serial loader: three-wire serial receiver and wiper latch
// Summary of operation
// R1: Three serial inputs (data, active-low select, clock) and no data output, so no readback.
// R2: While select is low, data is shifted in on every rising serial clock edge.
// R3: The controller sends each 8-bit code most significant bit first.
// R4: When select returns high, the shift register is copied into the wiper latch.
// R5: With more than eight bits in a frame, only the last eight received are latched.
// R6: Latched code D selects tap D of 256, code zero at the B end.
// R7: After reset the wiper latch holds the midscale code.
// R8: Serial clock edges while select is high change neither shifter nor latch.
module wcsl_loader
    import wcsl_pkg::*;
#(
    parameter int CODE_W = WCSL_CODE_W
)
(
    // System clock and reset
    input  wire logic              i_mclk,
    input  wire logic              i_srst,
    // Serial link (link clock domain)
    input  wire logic              i_sclk,
    input  wire logic              i_sel_n,
    input  wire logic              i_serial_data_in,
    // Wiper position
    output logic [CODE_W-1:0]      o_wiper_latch,
    output logic [WCSL_TAPS-1:0]   o_tap_sel,
    output logic                   o_load_pulse
);
    // Link clock domain: serial input register, no reset reaches this clock
    typedef struct packed {
        logic [CODE_W-1:0] shift; // Newest bit at bit 0, oldest at the top
    } wcsl_link_t;

    // Frame end domain: word taken on the rising select edge
    typedef struct packed {
        logic [CODE_W-1:0] hold; // Stable from one frame end to the next
    } wcsl_frame_t;

    // System clock domain: wiper latch and frame end detection
    typedef struct packed {
        logic [CODE_W-1:0] wiper;       // Wiper latch, sets the tap
        logic              active_seen; // Select was active last cycle
        logic              pulse;       // Marks the cycle of a latch update
    } wcsl_sys_t;

    // Reset image of the system state: midscale wiper, no frame open
    localparam wcsl_sys_t SYS_RESET = '{
        wiper:       CODE_W'(WCSL_MIDSCALE),
        active_seen: 1'b0,
        pulse:       1'b0
    };

    // State of the three domains and the crossing
    wcsl_link_t  lk_reg;
    wcsl_link_t  lk_next;
    wcsl_frame_t fr_reg;
    wcsl_frame_t fr_next;
    wcsl_sys_t   sy_reg;
    wcsl_sys_t   sy_next;
    logic        active_sync; // Select active, after two system flops
    logic        frame_end;   // Select has just returned high, system view

    // Link next state: one bit in per rising serial clock while selected
    always_comb
    begin
        lk_next = lk_reg;
        if (!i_sel_n) // R8
        begin
            lk_next.shift = {lk_reg.shift[CODE_W-2:0], i_serial_data_in}; // R2 R3 R5
        end
    end

    // Link register: the serial clock may stop between frames
    always_ff @(posedge i_sclk)
    begin
        lk_reg <= lk_next;
    end

    // Frame word: the last eight bits shifted in
    always_comb
    begin
        fr_next.hold = lk_reg.shift; // R4 R5
    end

    // Taken on the select rise itself, since no serial clock follows a frame
    always_ff @(posedge i_sel_n)
    begin
        fr_reg <= fr_next;
    end

    // Select activity crosses as a level; its idle level is low, like the
    // synchroniser's reset value, so leaving reset shows no false frame end.
    // The frame word needs no crossing of its own: it is still at the end.
    wcsl_toggle_sync i_wcsl_toggle_sync (
        .i_mclk  (i_mclk),
        .i_srst  (i_srst),
        .i_async (~i_sel_n),
        .o_sync  (active_sync)
    );

    // Frame end seen one or two cycles after the select rise
    assign frame_end = sy_reg.active_seen && !active_sync;

    // System next state: load the latch once per frame end
    always_comb
    begin
        sy_next             = sy_reg;
        sy_next.active_seen = active_sync;
        sy_next.pulse       = 1'b0;
        if (frame_end)
        begin
            sy_next.wiper = fr_reg.hold; // R4
            sy_next.pulse = 1'b1;
        end
    end

    // System register with synchronous reset to midscale
    always_ff @(posedge i_mclk)
    begin
        if (i_srst)
        begin
            sy_reg <= SYS_RESET; // R7
        end
        else
        begin
            sy_reg <= sy_next;
        end
    end

    // One-hot tap decode: code zero at the B end
    always_comb
    begin
        o_tap_sel = '0;
        o_tap_sel[sy_reg.wiper] = 1'b1; // R6
    end

    // Outputs straight from the system register
    assign o_wiper_latch = sy_reg.wiper; // R1
    assign o_load_pulse  = sy_reg.pulse;

    // Assertions in the system clock domain

    // Reset leaves the wiper at midscale
    a_reset_midscale: assert property (@(posedge i_mclk) // R7
        $fell(i_srst) |-> o_wiper_latch == CODE_W'(WCSL_MIDSCALE))
        else $error("wiper not midscale after reset");

    // No false load in the first two cycles after reset
    a_reset_no_load: assert property (@(posedge i_mclk) // R7
        $fell(i_srst) |-> !o_load_pulse ##1 !o_load_pulse)
        else $error("load pulse right after reset");

    // Wiper moves only with a load pulse
    a_latch_stable: assert property (@(posedge i_mclk) disable iff (i_srst) // R8
        !o_load_pulse |-> $stable(o_wiper_latch))
        else $error("wiper changed without a frame end");

    // No select activity, no load
    a_idle_no_load: assert property (@(posedge i_mclk) disable iff (i_srst) // R8
        !active_sync && !sy_reg.active_seen |=> !o_load_pulse)
        else $error("load without a frame");

    // Exactly the tap of the latched code
    a_tap_onehot: assert property (@(posedge i_mclk) disable iff (i_srst) // R6
        $onehot(o_tap_sel) && o_tap_sel[o_wiper_latch])
        else $error("tap select does not match code");

    // The B end tap belongs to code zero only
    a_zero_b_end: assert property (@(posedge i_mclk) disable iff (i_srst) // R6
        (o_wiper_latch == CODE_W'(WCSL_ZERO)) == o_tap_sel[0])
        else $error("B end tap not tied to code zero");

    // Frame end copies the frame word
    a_load_copies: assert property (@(posedge i_mclk) disable iff (i_srst) // R4
        frame_end |=> o_load_pulse && o_wiper_latch == $past(fr_reg.hold))
        else $error("frame end did not load the latch");

    // A load follows a frame end
    a_load_needs_end: assert property (@(posedge i_mclk) disable iff (i_srst) // R4
        o_load_pulse |-> $past(frame_end))
        else $error("load without a frame end");

    // One load per frame end
    a_pulse_single: assert property (@(posedge i_mclk) disable iff (i_srst) // R4
        o_load_pulse |=> !o_load_pulse)
        else $error("load pulse longer than one cycle");

    // Assertions in the link clock domain

    // Newest bit enters at the bottom
    a_shift_msb: assert property (@(posedge i_sclk) // R2
        !i_sel_n |=> lk_reg.shift[0] == $past(i_serial_data_in))
        else $error("serial bit not shifted in");

    // Deselected clock edges leave the shifter alone
    a_shift_hold: assert property (@(posedge i_sclk) // R8
        i_sel_n |=> $stable(lk_reg.shift))
        else $error("shifter moved while deselected");

    // Older bits move up one place, the oldest falls out
    a_surplus_drop: assert property (@(posedge i_sclk) // R5
        !i_sel_n |=> lk_reg.shift[CODE_W-1:1] === $past(lk_reg.shift[CODE_W-2:0]))
        else $error("shifter lost the last bits");

    // Coverage of the main scenarios
    c_load: cover property (@(posedge i_mclk) disable iff (i_srst) o_load_pulse);
    c_zero: cover property (@(posedge i_mclk) disable iff (i_srst)
        o_load_pulse && o_wiper_latch == CODE_W'(WCSL_ZERO));
    c_full: cover property (@(posedge i_mclk) disable iff (i_srst)
        o_load_pulse && &o_wiper_latch);
    c_stray_edge: cover property (@(posedge i_sclk) i_sel_n);
    c_second_reset: cover property (@(posedge i_mclk) $rose(i_srst));
endmodule : wcsl_loader

// ==== hw/wcsl_pkg.sv ====
// Constants shared by the wiper code serial loader
package wcsl_pkg;
    localparam int          WCSL_CODE_W   = 8;
    localparam int          WCSL_TAPS     = 256;
    localparam logic [7:0]  WCSL_MIDSCALE = 8'h80;
    localparam logic [7:0]  WCSL_ZERO     = 8'h00;
    localparam int          WCSL_SYNC_W   = 2;
endpackage : wcsl_pkg

// ==== hw/wcsl_toggle_sync.sv ====
// Two-flop synchroniser for a level crossing into the system clock domain
module wcsl_toggle_sync
    import wcsl_pkg::*;
(
    // Clock and reset
    input  wire logic i_mclk,
    input  wire logic i_srst,
    // Crossing signal
    input  wire logic i_async,
    output logic      o_sync
);
    typedef struct packed {
        logic meta;
        logic sync;
    } wcsl_sync_t;

    wcsl_sync_t st_reg;
    wcsl_sync_t st_next;

    // Next state: first flop feeds only the second
    always_comb
    begin
        st_next.meta = i_async;
        st_next.sync = st_reg.meta;
    end

    // State register
    always_ff @(posedge i_mclk)
    begin
        if (i_srst)
            st_reg <= '0;
        else
            st_reg <= st_next;
    end

    assign o_sync = st_reg.sync;
endmodule : wcsl_toggle_sync

// ==== testbench/wcsl_spi_host.sv ====
// Serial controller model for the three-wire link
module wcsl_spi_host
(
    // Serial link outputs
    output logic o_sclk,
    output logic o_sel_n,
    output logic o_sdi
);
    timeunit 1ns;
    timeprecision 1ps;
    // Idle link: clock still, select high
    initial
    begin
        o_sclk  = 1'b0;
        o_sel_n = 1'b1;
        o_sdi   = 1'b0;
    end
    // Frame of n bits, top bit first, 32 ns clock
    task automatic send(input logic [15:0] w, input int n);
        #32; // Select stays high one link period between frames
        o_sel_n = 1'b0;
        for (int k = n - 1; k >= 0; k--)
        begin
            o_sdi = w[k];
            #16 o_sclk = 1'b1;
            #16 o_sclk = 1'b0;
        end
        #16 o_sel_n = 1'b1;
        o_sdi = ~o_sdi; // Released data no longer shows the last bit
    endtask : send
    // Clock edges with select high
    task automatic stray(input int n);
        repeat (n)
        begin
            o_sdi = ~o_sdi;
            #16 o_sclk = 1'b1;
            #16 o_sclk = 1'b0;
        end
    endtask : stray
endmodule : wcsl_spi_host

// ==== testbench/wcsl_loader_tb_top.sv ====
// Testbench top for the wiper code serial loader
module wcsl_loader_tb_top
    import wcsl_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic         i_mclk = 1'b0;
    logic         i_srst = 1'b1;
    logic         sclk, sel_n, serial_data_in, load;
    logic [7:0]   wiper;
    logic [255:0] tap;
    int           fail_count = 0;
    int           num_checks = 0;
    // System clock, 4 ns
    always #2 i_mclk = ~i_mclk;
    wcsl_spi_host i_wcsl_spi_host (.o_sclk(sclk), .o_sel_n(sel_n), .o_sdi(serial_data_in));
    wcsl_loader i_wcsl_loader (.i_mclk(i_mclk), .i_srst(i_srst), .i_sclk(sclk),
        .i_sel_n(sel_n), .i_serial_data_in(serial_data_in), .o_wiper_latch(wiper),
        .o_tap_sel(tap), .o_load_pulse(load));
    // Compare and count
    task automatic check(input string what, input logic [255:0] seen, input logic [255:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("Error %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : check
    // Verdict and end of run
    task automatic tally_and_finish;
        $display("Checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : tally_and_finish
    // Reset for n cycles, outputs at midscale
    task automatic t_reset(input int n);
        i_srst = 1'b1;
        repeat (n) @(negedge i_mclk);
        check("wiper", wiper, WCSL_MIDSCALE);
        check("tap", tap, 256'h1 << 128);
        check("load", load, 1'b0);
        i_srst = 1'b0;
        repeat (2) @(negedge i_mclk);
        check("wiper", wiper, WCSL_MIDSCALE);
        check("load", load, 1'b0);
    endtask : t_reset
    // Wait for the load pulse, then judge it
    task automatic wait_load(input logic [7:0] d);
        int n;
        n = 0;
        while (load !== 1'b1 && n < 40)
        begin
            @(negedge i_mclk);
            n++;
        end
        check("load", load, 1'b1);
        check("latency", n <= 4, 1'b1);
        check("wiper", wiper, d);
        check("tap", tap, 256'h1 << d);
        @(negedge i_mclk);
        check("pulse", load, 1'b0);
    endtask : wait_load
    // Whole frames with boundary codes
    task automatic t_codes;
        logic [7:0] c [5] = '{8'h00, 8'hFF, 8'h5A, 8'hA5, 8'h01};
        foreach (c[i])
        begin
            i_wcsl_spi_host.send({8'h00, c[i]}, 8);
            wait_load(c[i]);
        end
    endtask : t_codes
    // Twelve bits: the last eight stay
    task automatic t_overlong;
        i_wcsl_spi_host.send(16'h3C96, 12);
        wait_load(8'h96);
    endtask : t_overlong
    // Clock edges while deselected change nothing
    task automatic t_stray;
        i_wcsl_spi_host.stray(5);
        repeat (10) @(negedge i_mclk);
        check("wiper", wiper, 8'h96);
        check("load", load, 1'b0);
        i_wcsl_spi_host.send(16'h0000, 3);
        wait_load(8'hB0);
    endtask : t_stray
    // Main sequence
    initial
    begin
        t_reset(20);
        t_codes();
        t_overlong();
        t_stray();
        t_reset(3);
        tally_and_finish();
    end
    // Watchdog
    initial
    begin
        #20000;
        fail_count++;
        tally_and_finish();
    end
endmodule : wcsl_loader_tb_top
